// >>> wwdt_core.sv
`timescale 1ns/1ps
module wwdt_core
	import wwdt_pkg::*;
#(
	parameter int PRESCALE = WWDT_PRESCALE_DIVIDE
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	input  wire logic        i_slow_clock,
	input  wire logic        i_debug_state,
	input  wire logic        i_idle_mode,
	input  wire logic [3:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_write,
	input  wire logic        i_read,
	output logic      [31:0] o_rdata,
	output logic             o_irq,
	output logic             o_fault,
	output logic             o_fault_all_resets,
	output logic             o_fault_proc_reset
);

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic       slow_prev_reg;
	logic       slow_rise;
	logic       debug_sync;
	logic       idle_sync;

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
			slow_prev_reg <= 1'b0;
		end else begin
			sync1_reg <= {i_idle_mode, i_debug_state, i_slow_clock};
			sync2_reg <= sync1_reg;
			slow_prev_reg <= sync2_reg[0];
		end
	end

	assign slow_rise  = sync2_reg[0] & ~slow_prev_reg;
	assign debug_sync = sync2_reg[1];
	assign idle_sync  = sync2_reg[2];

	// ---------------------------------------------------------------
	// configuration register, write once
	// ---------------------------------------------------------------
	logic [31:0] config_reg;
	logic        config_locked_reg;
	logic        config_write;
	logic [11:0] reload_value;
	logic [11:0] delta_value;
	logic        fault_interrupt_enable;
	logic        fault_reset_enable;
	logic        processor_reset_only;
	logic        timer_disable;
	logic        debug_halt;
	logic        idle_halt;

	assign config_write = i_write && (i_addr == WWDT_OFS_CONFIGURATION) && !config_locked_reg;

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			config_reg <= WWDT_CONFIG_RESET;
			config_locked_reg <= 1'b0;
		end else if (config_write) begin
			config_reg <= i_wdata & WWDT_CONFIG_MASK;
			config_locked_reg <= 1'b1;
		end
	end

	assign reload_value           = config_reg[WWDT_RELOAD_LSB +: WWDT_RELOAD_W];
	assign delta_value            = config_reg[WWDT_DELTA_LSB +: WWDT_RELOAD_W];
	assign fault_interrupt_enable = config_reg[WWDT_FIEN_BIT];
	assign fault_reset_enable     = config_reg[WWDT_RSTEN_BIT];
	assign processor_reset_only   = config_reg[WWDT_PROC_ONLY_BIT];
	assign timer_disable          = config_reg[WWDT_DISABLE_BIT];
	assign debug_halt             = config_reg[WWDT_DBG_HALT_BIT];
	assign idle_halt              = config_reg[WWDT_IDLE_HALT_BIT];

	// ---------------------------------------------------------------
	// restart command decode
	// ---------------------------------------------------------------
	logic        restart_request;
	logic        restart_ok;
	logic        restart_err;
	logic [11:0] count_reg;

	assign restart_request = i_write && (i_addr == WWDT_OFS_RESTART_COMMAND)
		&& (i_wdata[WWDT_KEY_LSB +: 8] == WWDT_KEY_VALUE)
		&& i_wdata[WWDT_RESTART_BIT];
	// window compare against live count; delta >= reload never errs
	assign restart_err = restart_request && (count_reg > delta_value);
	assign restart_ok  = restart_request && !restart_err;

	// ---------------------------------------------------------------
	// prescaler and down counter
	// ---------------------------------------------------------------
	localparam int PW = $clog2(PRESCALE);
	logic [PW-1:0] presc_reg;
	logic          running;
	logic          tick;
	logic          underflow;

	// halts freeze the prescaler too, so a resumed period is not cut short
	assign running = !timer_disable && !(debug_halt && debug_sync)
		&& !(idle_halt && idle_sync);
	assign tick = running && slow_rise && (presc_reg == PW'(PRESCALE - 1));
	assign underflow = tick && (count_reg == 12'h000);

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			presc_reg <= '0;
		end else if (restart_ok || config_write) begin
			presc_reg <= '0;
		end else if (running && slow_rise) begin
			presc_reg <= (presc_reg == PW'(PRESCALE - 1)) ? '0 : presc_reg + 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			count_reg <= WWDT_CONFIG_RESET[WWDT_RELOAD_LSB +: WWDT_RELOAD_W];
		end else if (config_write) begin
			count_reg <= i_wdata[WWDT_RELOAD_LSB +: WWDT_RELOAD_W];
		end else if (restart_ok) begin
			count_reg <= reload_value;
		end else if (underflow) begin
			count_reg <= reload_value;
		end else if (tick) begin
			count_reg <= count_reg - 12'h001;
		end
	end

	// ---------------------------------------------------------------
	// status flags and fault line
	// ---------------------------------------------------------------
	logic status_read;
	logic unf_reg;
	logic err_reg;
	logic fault_reg;

	assign status_read = i_read && (i_addr == WWDT_OFS_FAULT_STATUS);

	// set wins over a clearing read in the same cycle
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			unf_reg <= 1'b0;
			err_reg <= 1'b0;
			fault_reg <= 1'b0;
		end else begin
			if (underflow) begin
				unf_reg <= 1'b1;
			end else if (status_read) begin
				unf_reg <= 1'b0;
			end
			if (restart_err) begin
				err_reg <= 1'b1;
			end else if (status_read) begin
				err_reg <= 1'b0;
			end
			if ((underflow && fault_reset_enable) || restart_err) begin
				fault_reg <= 1'b1;
			end else if (status_read) begin
				fault_reg <= 1'b0;
			end
		end
	end

	assign o_irq = fault_interrupt_enable && (unf_reg || err_reg);
	assign o_fault = fault_reg;
	assign o_fault_all_resets = fault_reg && fault_reset_enable && !processor_reset_only;
	assign o_fault_proc_reset = fault_reg && fault_reset_enable && processor_reset_only;

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= 32'h0;
		end else if (i_read && (i_addr == WWDT_OFS_CONFIGURATION)) begin
			o_rdata <= config_reg;
		end else if (status_read) begin
			o_rdata <= {30'h0, err_reg, unf_reg};
		end else begin
			o_rdata <= 32'h0;
		end
	end

endmodule

// >>> wwdt_pkg.sv
package wwdt_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [3:0] WWDT_OFS_RESTART_COMMAND = 4'h0;
	localparam logic [3:0] WWDT_OFS_CONFIGURATION   = 4'h4;
	localparam logic [3:0] WWDT_OFS_FAULT_STATUS    = 4'h8;

	// ---------------------------------------------------------------
	// field layout
	// ---------------------------------------------------------------
	localparam int WWDT_RELOAD_LSB    = 0;
	localparam int WWDT_RELOAD_W      = 12;
	localparam int WWDT_FIEN_BIT      = 12;
	localparam int WWDT_RSTEN_BIT     = 13;
	localparam int WWDT_PROC_ONLY_BIT = 14;
	localparam int WWDT_DISABLE_BIT   = 15;
	localparam int WWDT_DELTA_LSB     = 16;
	localparam int WWDT_DBG_HALT_BIT  = 28;
	localparam int WWDT_IDLE_HALT_BIT = 29;
	localparam int WWDT_KEY_LSB       = 24;
	localparam int WWDT_RESTART_BIT   = 0;
	localparam int WWDT_UNF_BIT       = 0;
	localparam int WWDT_ERR_BIT       = 1;

	// ---------------------------------------------------------------
	// values
	// ---------------------------------------------------------------
	localparam logic [7:0]  WWDT_KEY_VALUE       = 8'ha5;
	localparam logic [31:0] WWDT_CONFIG_RESET    = 32'h3fff2fff;
	localparam logic [31:0] WWDT_CONFIG_MASK     = 32'h3fffffff;
	localparam int          WWDT_PRESCALE_DIVIDE = 128;

endpackage

// >>> wwdt_checker.sv
`timescale 1ns/1ps
module wwdt_checker
	import wwdt_pkg::*;
#(
	parameter int PRESCALE = WWDT_PRESCALE_DIVIDE
) (
	input wire logic        i_clock,
	input wire logic        i_rst_b,
	input wire logic [3:0]  i_addr,
	input wire logic        i_read,
	input wire logic [31:0] o_rdata,
	input wire logic        o_irq,
	input wire logic        o_fault,
	input wire logic        o_fault_all_resets,
	input wire logic        o_fault_proc_reset
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	sequence s_stat_rd;
		i_read && i_addr == WWDT_OFS_FAULT_STATUS;
	endsequence
	// a fault raised in the read cycle itself would win; not exercised
	property p_fault_clr; s_stat_rd |=> !o_fault; endproperty
	property p_fault_hold; o_fault && !(i_read && i_addr == WWDT_OFS_FAULT_STATUS) |=> o_fault; endproperty
	property p_irq_fall; $fell(o_irq) |-> $past(i_read && i_addr == WWDT_OFS_FAULT_STATUS); endproperty
	property p_all; o_fault_all_resets |-> o_fault && !o_fault_proc_reset; endproperty
	property p_proc; o_fault_proc_reset |-> o_fault; endproperty
	property p_shape; s_stat_rd |=> o_rdata[31:2] == 30'h0; endproperty
	property p_fault_flag; o_fault ##0 s_stat_rd |=> o_rdata[1:0] != 2'h0; endproperty
	property p_irq_flag; o_irq ##0 s_stat_rd |=> o_rdata[1:0] != 2'h0; endproperty
	property p_rst_quiet; $rose(i_rst_b) |-> !o_fault && !o_irq; endproperty
	a_fault_clr: assert property (p_fault_clr) else $error("fault kept after status read");
	a_fault_hold: assert property (p_fault_hold) else $error("fault dropped early");
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without status read");
	a_all: assert property (p_all) else $error("all-resets line wrong");
	a_proc: assert property (p_proc) else $error("processor reset without fault");
	a_shape: assert property (p_shape) else $error("status upper bits set");
	a_fault_flag: assert property (p_fault_flag) else $error("fault with no flag");
	a_irq_flag: assert property (p_irq_flag) else $error("irq with no flag");
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
endmodule
bind wwdt_core wwdt_checker #(.PRESCALE(PRESCALE)) u_chk (.i_clock(i_clock), .i_rst_b(i_rst_b),
	.i_addr(i_addr), .i_read(i_read), .o_rdata(o_rdata), .o_irq(o_irq), .o_fault(o_fault),
	.o_fault_all_resets(o_fault_all_resets), .o_fault_proc_reset(o_fault_proc_reset));

// >>> wwdt_sys_model.sv
`timescale 1ns/1ps
module wwdt_sys_model (
	input  wire logic i_clock,
	input  wire logic i_debug_req,
	input  wire logic i_idle_req,
	output logic      o_slow_clock,
	output logic      o_debug_state,
	output logic      o_idle_mode
);
	// free-running slow clock, well under half the system rate
	int cnt = 0;
	initial o_slow_clock = 1'b0;
	always @(posedge i_clock) begin
		cnt <= (cnt == 3) ? 0 : cnt + 1;
		if (cnt == 3) begin
			o_slow_clock <= ~o_slow_clock;
		end
	end
	assign o_debug_state = i_debug_req;
	assign o_idle_mode   = i_idle_req;
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
	import wwdt_pkg::*;
	localparam logic [31:0] CFG = 32'h00043008;
	logic        clock = 1'b0;
	logic        rst_b, wr_stb, rd_stb, irq, fault, f_all, f_proc, slow, dbg, idle;
	logic        dbg_req, idle_req;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, got;
	int          err_count = 0;
	int          num_checks = 0;
	always #20 clock = ~clock;
	wwdt_sys_model i_sys (.i_clock(clock), .i_debug_req(dbg_req), .i_idle_req(idle_req), .o_slow_clock(slow),
		.o_debug_state(dbg), .o_idle_mode(idle));
	wwdt_core #(.PRESCALE(2)) i_dut (.i_clock(clock), .i_rst_b(rst_b), .i_slow_clock(slow),
		.i_debug_state(dbg), .i_idle_mode(idle), .i_addr(addr), .i_wdata(wdata), .i_write(wr_stb),
		.i_read(rd_stb), .o_rdata(rdata), .o_irq(irq), .o_fault(fault), .o_fault_all_resets(f_all),
		.o_fault_proc_reset(f_proc));
	task automatic final_report();
		if (err_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
		@(posedge clock);
		#1;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1;
		got = rdata;
	endtask
	task automatic t_reset_values();
		rd(WWDT_OFS_CONFIGURATION);
		`CHK(got, 32'h3fff2fff)
		rd(WWDT_OFS_FAULT_STATUS);
		`CHK(got, 32'h0)
		rd(4'hc);
		`CHK(got, 32'h0)
	endtask
	task automatic t_write_once();
		wr(WWDT_OFS_CONFIGURATION, CFG);
		wr(WWDT_OFS_CONFIGURATION, 32'h0);
		rd(WWDT_OFS_CONFIGURATION);
		`CHK(got, CFG)
	endtask
	task automatic t_key_and_error();
		wr(WWDT_OFS_RESTART_COMMAND, 32'h5a000001);
		wr(WWDT_OFS_RESTART_COMMAND, 32'ha5000000);
		`CHK(fault, 1'b0)
		wr(WWDT_OFS_RESTART_COMMAND, 32'ha5000001);
		`CHK({fault, irq, f_all, f_proc}, 4'he)
		rd(WWDT_OFS_FAULT_STATUS);
		`CHK(got, 32'h2)
		`CHK({fault, irq}, 2'h0)
	endtask
	task automatic t_underflow_window();
		int n;
		for (n = 0; n < 400 && fault !== 1'b1; n++) begin
			@(posedge clock);
		end
		#1;
		`CHK(n < 400, 1'b1)
		if (n >= 400) begin
			final_report();
		end
		`CHK({f_all, f_proc}, 2'h2)
		rd(WWDT_OFS_FAULT_STATUS);
		`CHK(got, 32'h1)
		// counter reloads to 8 at underflow, so ~6 ticks later it sits inside the window
		repeat (100) @(posedge clock);
		wr(WWDT_OFS_RESTART_COMMAND, 32'ha5000001);
		`CHK(fault, 1'b0)
		repeat (100) @(posedge clock);
		`CHK(fault, 1'b0)
		rd(WWDT_OFS_FAULT_STATUS);
		`CHK(got, 32'h0)
	endtask
	task automatic t_second_reset();
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		rd(WWDT_OFS_CONFIGURATION);
		`CHK(got, 32'h3fff2fff)
	endtask
	task automatic t_halts_and_disable();
		int n;
		@(posedge clock);
		dbg_req <= 1'b1;
		wr(WWDT_OFS_CONFIGURATION, 32'h30047004);
		repeat (200) @(posedge clock);
		`CHK(fault, 1'b0)
		dbg_req <= 1'b0;
		idle_req <= 1'b1;
		repeat (200) @(posedge clock);
		`CHK(fault, 1'b0)
		idle_req <= 1'b0;
		for (n = 0; n < 200 && fault !== 1'b1; n++) begin
			@(posedge clock);
		end
		#1;
		`CHK(n < 200, 1'b1)
		if (n >= 200) begin
			final_report();
		end
		`CHK({irq, f_all, f_proc}, 3'h5)
		rd(WWDT_OFS_FAULT_STATUS);
		`CHK(got, 32'h1)
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		// disabled, delta below reload: a restart must still flag an error
		wr(WWDT_OFS_CONFIGURATION, 32'h0002b004);
		repeat (200) @(posedge clock);
		`CHK(fault, 1'b0)
		wr(WWDT_OFS_RESTART_COMMAND, 32'ha5000001);
		`CHK(fault, 1'b1)
	endtask
	initial begin
		rst_b = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		dbg_req = 1'b0;
		idle_req = 1'b0;
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		t_reset_values();
		t_write_once();
		t_key_and_error();
		t_underflow_window();
		t_second_reset();
		t_halts_and_disable();
		final_report();
	end
endmodule
